// ===== cmsg_pkg.sv
// constants and types for the clock mux and start-up lock gate
// Operation
// (R1) waiting manager holds start-up before user mode
// (R2) user mode only when all waiting managers lock_indicator
// (R3) one of six cycles stalls until lock
// (R4) select 0 picks input zero, 1 input one
// (R5) switching between async clocks makes no glitch
// (R6) no output phase shorter than input phases
// (R7) plain buffer passes one clock, no select
// (R8) gated buffer uses select as clean enable
// (R9) 24 muxes: 8 global, 8 left, 8 right
// (R10) pairs share inputs, zero feeds partner's one
// (R11) side matrix: half pin, double line, manager
// (R12) top/bottom matrix: two pins, two managers, line; code feeds each matrix one manager (manager_out_i[s])
// (R13) each top/bottom pair takes four edge pins
// (R14) side pair fed by exactly two pins
// (R15) 16 global, 8 right, 8 left pins, readable
// (R16) pins feed managers over direct paths
// (R17) lock indicator high only while phases match
// (R18) manager reset forces lock indicator low
// (R19) select synced per clock, switch while low
// (R20) non-waiting manager never affects stall release
package cmsg_pkg;

  // ----------------------------------------
  // sizes
  // ----------------------------------------
  localparam int MUX_COUNT = 24;
  localparam int MGR_COUNT = 8;
  localparam int PIN_COUNT = 32;
  localparam int STEP_DIV = 4;

  // ----------------------------------------
  // register byte offsets
  // ----------------------------------------
  localparam logic [7:0] ADDR_STARTUP = 8'h00;
  localparam logic [7:0] ADDR_WAIT_MASK = 8'h04;
  localparam logic [7:0] ADDR_MGR_RESET = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;
  localparam logic [7:0] ADDR_MUX_SEL = 8'h10;
  localparam logic [7:0] ADDR_SRC_LO = 8'h14;
  localparam logic [7:0] ADDR_SRC_HI = 8'h18;
  localparam logic [7:0] ADDR_PIN_LEVEL = 8'h1C;

  // ----------------------------------------
  // fields, reset values and start-up timing
  // ----------------------------------------
  localparam int RESTART_BIT = 8;
  localparam int STAT_STALL_BIT = 4;
  localparam int STAT_USER_BIT = 5;
  localparam int STAT_LOCK_LSB = 8;
  localparam logic [2:0] LOCK_SEL_RST = 3'h0;
  localparam logic [2:0] LOCK_SEL_MAX = 3'h5;
  localparam logic [2:0] PHASE_LAST = 3'h6;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // switch matrix source codes
  localparam logic [1:0] SRC_PIN_A = 2'h0;
  localparam logic [1:0] SRC_PIN_B = 2'h1;
  localparam logic [1:0] SRC_MGR = 2'h2;

  typedef enum logic [1:0] {
    KIND_MUX = 2'b00,
    KIND_PLAIN = 2'b01,
    KIND_GATED = 2'b10
  } cmsg_kind_t;

  typedef enum logic [1:0] {
    SEQ_RUN = 2'b00,
    SEQ_STALL = 2'b01,
    SEQ_USER = 2'b10
  } cmsg_seq_t;

endpackage

// ===== cmsg_glitchless_clock_mux.sv
// glitch-free two-input clock multiplexer cell with buffer variants
`timescale 1ns/1ps
module cmsg_glitchless_clock_mux #(
  parameter cmsg_pkg::cmsg_kind_t KIND = cmsg_pkg::KIND_MUX
) (
  input wire logic rst_i,
  input wire logic mux_input_zero_i,
  input wire logic mux_input_one_i,
  input wire logic sel_i,
  output logic clk_o
);

  // ----------------------------------------
  // variants
  // ----------------------------------------
  if (KIND == cmsg_pkg::KIND_PLAIN)
  begin : g_plain
    // select path left out entirely
    assign clk_o = mux_input_zero_i; // [R7]
  end
  else if (KIND == cmsg_pkg::KIND_GATED)
  begin : g_gated
    logic s_a_q, s_b_q, en_q;
    // enable synced into the clock, applied while the clock is low
    always_ff @(posedge mux_input_zero_i or posedge rst_i)
      if (rst_i)
      begin
        s_a_q <= 1'b0;
        s_b_q <= 1'b0;
      end
      else
      begin
        s_a_q <= sel_i;
        s_b_q <= s_a_q;
      end
    always_ff @(negedge mux_input_zero_i or posedge rst_i)
      if (rst_i)
        en_q <= 1'b0;
      else
        en_q <= s_b_q; // [R8]
    assign clk_o = mux_input_zero_i & en_q; // [R8]

    chk_gate_follows: assert property (@(posedge mux_input_zero_i) disable iff (rst_i) // [R8]
      sel_i [*4] |-> en_q)
      else $error("gated buffer did not open after enable");
  end
  else
  begin : g_mux
    logic z_a_q, z_b_q, en0_q;
    logic o_a_q, o_b_q, en1_q;
    // each side asks only once the other side has let go
    always_ff @(posedge mux_input_zero_i or posedge rst_i)
      if (rst_i)
      begin
        z_a_q <= 1'b0;
        z_b_q <= 1'b0;
      end
      else
      begin
        z_a_q <= ~sel_i & ~en1_q; // [R19]
        z_b_q <= z_a_q;
      end
    // enable changes on the falling edge so a high phase is never cut
    always_ff @(negedge mux_input_zero_i or posedge rst_i)
      if (rst_i)
        en0_q <= 1'b0;
      else
        en0_q <= z_b_q; // [R6] [R19]
    always_ff @(posedge mux_input_one_i or posedge rst_i)
      if (rst_i)
      begin
        o_a_q <= 1'b0;
        o_b_q <= 1'b0;
      end
      else
      begin
        o_a_q <= sel_i & ~en0_q; // [R19]
        o_b_q <= o_a_q;
      end
    always_ff @(negedge mux_input_one_i or posedge rst_i)
      if (rst_i)
        en1_q <= 1'b0;
      else
        en1_q <= o_b_q; // [R6] [R19]
    // at most one gated clock reaches the output
    assign clk_o = (mux_input_zero_i & en0_q) | (mux_input_one_i & en1_q); // [R4] [R5]

    chk_enables_exclusive: assert property (@(posedge mux_input_zero_i) disable iff (rst_i) // [R5]
      !(en0_q && en1_q))
      else $error("both mux inputs enabled at once");
    chk_zero_handover: assert property (@(negedge mux_input_zero_i) disable iff (rst_i) // [R19]
      $rose(en0_q) |-> !en1_q)
      else $error("input zero enabled before input one released");
  end

endmodule

// ===== cmsg_clock_mux_startup_lock_gate.sv
// clock switch matrices, 24 clock muxes and the start-up lock gate
`timescale 1ns/1ps
module cmsg_clock_mux_startup_lock_gate #(
  parameter logic [47:0] MUX_KIND = 48'h0,
  parameter bit SIDE_MGR_EN = 1'b1,
  parameter int STEP_DIV = cmsg_pkg::STEP_DIV
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  // axi4-lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // clock sources
  input wire logic [15:0] global_clock_pin_i,
  input wire logic [7:0] left_half_clock_pin_i,
  input wire logic [7:0] right_half_clock_pin_i,
  input wire logic [23:0] double_line_i,
  input wire logic [7:0] manager_out_i,
  input wire logic [7:0] lock_indicator_i,
  // clock network and start-up
  output logic [7:0] manager_input_clock_o,
  output logic [7:0] manager_reset_o,
  output logic [7:0] global_clk_o,
  output logic [7:0] left_half_clk_o,
  output logic [7:0] right_half_clk_o,
  output logic user_mode_o,
  output logic startup_stalled_o
);

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  logic aw_full_q, w_full_q, aw_full_d, w_full_d;
  logic [7:0] wr_addr_q;
  logic [31:0] wr_data_q;
  logic [3:0] wr_strb_q;
  logic aw_take, w_take, wr_fire, b_done, ar_take;
  logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q;
  logic [2:0] lock_sel_q, stall_phase, phase_q;
  logic [7:0] wait_mask_q, mgr_rst_q, lock_s1_q, lock_s2_q, lock_eff;
  logic [23:0] mux_sel_q, line_src, mux_clk;
  logic [47:0] src_sel_q;
  logic [31:0] pin_all, pin_s1_q, pin_s2_q;
  logic restart_q, step_q, lock_ok, user_q, stall_q;
  logic [7:0] div_q;
  cmsg_pkg::cmsg_seq_t state_q;

  function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] wd,
                                         input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++)
      if (st[b])
        r[8*b +: 8] = wd[8*b +: 8];
    return r;
  endfunction

  // ----------------------------------------
  // axi4-lite write channel
  // ----------------------------------------
  assign aw_take = s_axi_awvalid && awready_q;
  assign w_take = s_axi_wvalid && wready_q;
  assign wr_fire = aw_full_q && w_full_q && !bvalid_q;
  assign b_done = bvalid_q && s_axi_bready;

  // address and data are held until the response is accepted
  always_comb
  begin
    aw_full_d = aw_full_q;
    w_full_d = w_full_q;
    if (aw_take)
      aw_full_d = 1'b1;
    if (w_take)
      w_full_d = 1'b1;
    if (b_done)
    begin
      aw_full_d = 1'b0;
      w_full_d = 1'b0;
    end
  end

  always_ff @(posedge core_clk_i)
    if (rst_i)
    begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= cmsg_pkg::RESP_OKAY;
      wr_addr_q <= 8'h00;
      wr_data_q <= 32'h0;
      wr_strb_q <= 4'h0;
    end
    else
    begin
      aw_full_q <= aw_full_d;
      w_full_q <= w_full_d;
      awready_q <= !aw_full_d;
      wready_q <= !w_full_d;
      if (aw_take)
        wr_addr_q <= s_axi_awaddr;
      if (w_take)
      begin
        wr_data_q <= s_axi_wdata;
        wr_strb_q <= s_axi_wstrb;
      end
      if (wr_fire)
      begin
        bvalid_q <= 1'b1;
        bresp_q <= (wr_addr_q > cmsg_pkg::ADDR_PIN_LEVEL || wr_addr_q[1:0] != 2'h0) ?
                   cmsg_pkg::RESP_DECERR : cmsg_pkg::RESP_OKAY;
      end
      else if (b_done)
        bvalid_q <= 1'b0;
    end

  // register updates; read-only words ignore writes
  always_ff @(posedge core_clk_i)
    if (rst_i)
    begin
      lock_sel_q <= cmsg_pkg::LOCK_SEL_RST;
      wait_mask_q <= 8'h00;
      mgr_rst_q <= 8'h00;
      mux_sel_q <= 24'h0;
      src_sel_q <= 48'h0;
      restart_q <= 1'b0;
    end
    else
    begin
      restart_q <= wr_fire && wr_addr_q == cmsg_pkg::ADDR_STARTUP && wr_strb_q[1] &&
                   wr_data_q[cmsg_pkg::RESTART_BIT];
      if (wr_fire)
        case (wr_addr_q)
          cmsg_pkg::ADDR_STARTUP:
            lock_sel_q <= 3'(wmerge({29'h0, lock_sel_q}, wr_data_q, wr_strb_q));
          cmsg_pkg::ADDR_WAIT_MASK:
            wait_mask_q <= 8'(wmerge({24'h0, wait_mask_q}, wr_data_q, wr_strb_q));
          cmsg_pkg::ADDR_MGR_RESET:
            mgr_rst_q <= 8'(wmerge({24'h0, mgr_rst_q}, wr_data_q, wr_strb_q));
          cmsg_pkg::ADDR_MUX_SEL:
            mux_sel_q <= 24'(wmerge({8'h0, mux_sel_q}, wr_data_q, wr_strb_q));
          cmsg_pkg::ADDR_SRC_LO:
            src_sel_q[31:0] <= wmerge(src_sel_q[31:0], wr_data_q, wr_strb_q);
          cmsg_pkg::ADDR_SRC_HI:
            src_sel_q[47:32] <= 16'(wmerge({16'h0, src_sel_q[47:32]}, wr_data_q, wr_strb_q));
          default:
            lock_sel_q <= lock_sel_q;
        endcase
    end

  // ----------------------------------------
  // axi4-lite read channel
  // ----------------------------------------
  assign ar_take = s_axi_arvalid && arready_q;

  always_ff @(posedge core_clk_i)
    if (rst_i)
    begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0;
      rresp_q <= cmsg_pkg::RESP_OKAY;
    end
    else if (ar_take)
    begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b1;
      rresp_q <= cmsg_pkg::RESP_OKAY;
      case (s_axi_araddr)
        cmsg_pkg::ADDR_STARTUP: rdata_q <= {29'h0, lock_sel_q};
        cmsg_pkg::ADDR_WAIT_MASK: rdata_q <= {24'h0, wait_mask_q};
        cmsg_pkg::ADDR_MGR_RESET: rdata_q <= {24'h0, mgr_rst_q};
        cmsg_pkg::ADDR_STATUS:
          rdata_q <= {16'h0, lock_eff, 2'h0, user_q, stall_q, 1'b0, phase_q};
        cmsg_pkg::ADDR_MUX_SEL: rdata_q <= {8'h0, mux_sel_q};
        cmsg_pkg::ADDR_SRC_LO: rdata_q <= src_sel_q[31:0];
        cmsg_pkg::ADDR_SRC_HI: rdata_q <= {16'h0, src_sel_q[47:32]};
        cmsg_pkg::ADDR_PIN_LEVEL: rdata_q <= pin_s2_q; // [R15]
        default:
        begin
          rdata_q <= 32'h0;
          rresp_q <= cmsg_pkg::RESP_DECERR;
        end
      endcase
    end
    else
    begin
      if (rvalid_q && s_axi_rready)
        rvalid_q <= 1'b0;
      arready_q <= !rvalid_q || s_axi_rready;
    end

  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  // ----------------------------------------
  // pin and lock synchronisers
  // ----------------------------------------
  assign pin_all = {left_half_clock_pin_i, right_half_clock_pin_i, global_clock_pin_i};

  // pins and lock indicators are asynchronous to the core clock
  always_ff @(posedge core_clk_i)
    if (rst_i)
    begin
      lock_s1_q <= 8'h00;
      lock_s2_q <= 8'h00;
      pin_s1_q <= 32'h0;
      pin_s2_q <= 32'h0;
    end
    else
    begin
      lock_s1_q <= lock_indicator_i;
      lock_s2_q <= lock_s1_q; // [R17]
      pin_s1_q <= pin_all;
      pin_s2_q <= pin_s1_q; // [R15]
    end

  // a manager held in reset never counts as lock_indicator
  assign lock_eff = lock_s2_q & ~mgr_rst_q; // [R18]
  assign manager_reset_o = mgr_rst_q; // [R18]
  // managers left out of the wait mask count as ready
  assign lock_ok = &(lock_eff | ~wait_mask_q); // [R2] [R20]
  // only six stall points exist, larger codes use the last
  assign stall_phase = (lock_sel_q > cmsg_pkg::LOCK_SEL_MAX) ?
                       cmsg_pkg::LOCK_SEL_MAX : lock_sel_q; // [R3]

  // ----------------------------------------
  // start-up sequencer
  // ----------------------------------------
  // sequencer step rate, one pulse per STEP_DIV core cycles
  always_ff @(posedge core_clk_i)
    if (rst_i || div_q == 8'(STEP_DIV - 1))
      div_q <= 8'h00;
    else
      div_q <= 8'(div_q + 8'h01);

  always_ff @(posedge core_clk_i)
    if (rst_i)
      step_q <= 1'b0;
    else
      step_q <= div_q == 8'(STEP_DIV - 1);

  always_ff @(posedge core_clk_i)
    if (rst_i || restart_q)
    begin
      state_q <= cmsg_pkg::SEQ_RUN;
      phase_q <= 3'h0;
    end
    else if (step_q)
      case (state_q)
        cmsg_pkg::SEQ_RUN:
          if (phase_q == stall_phase && !lock_ok)
            state_q <= cmsg_pkg::SEQ_STALL; // [R1] [R3]
          else if (phase_q == cmsg_pkg::PHASE_LAST)
            state_q <= cmsg_pkg::SEQ_USER;
          else
            phase_q <= 3'(phase_q + 3'h1);
        cmsg_pkg::SEQ_STALL:
          if (lock_ok)
          begin
            state_q <= cmsg_pkg::SEQ_RUN; // [R2]
            phase_q <= 3'(phase_q + 3'h1);
          end
        cmsg_pkg::SEQ_USER:
          state_q <= cmsg_pkg::SEQ_USER;
        default:
          state_q <= cmsg_pkg::SEQ_RUN;
      endcase

  always_ff @(posedge core_clk_i)
    if (rst_i)
    begin
      user_q <= 1'b0;
      stall_q <= 1'b0;
    end
    else
    begin
      user_q <= state_q == cmsg_pkg::SEQ_USER;
      stall_q <= state_q == cmsg_pkg::SEQ_STALL;
    end

  assign user_mode_o = user_q;
  assign startup_stalled_o = stall_q;

  // ----------------------------------------
  // switch matrices and clock muxes
  // ----------------------------------------
  // first pin of each four-pin group feeds one manager directly
  for (genvar m = 0; m < cmsg_pkg::MGR_COUNT; m++)
  begin : g_mgr_in
    assign manager_input_clock_o[m] = pin_all[4*m]; // [R16]
  end

  for (genvar s = 0; s < cmsg_pkg::MUX_COUNT; s++)
  begin : g_line
    localparam int J = s % 2;
    localparam int P = s / 2;
    logic pin_a, pin_b, mgr_src;
    logic [1:0] src;
    if (s < 8)
    begin : g_global
      // a pair sees four of its edge's eight pins
      assign pin_a = global_clock_pin_i[4*P+J]; // [R12] [R13]
      assign pin_b = global_clock_pin_i[4*P+2+J]; // [R12] [R13]
      assign mgr_src = manager_out_i[s];
    end
    else
    begin : g_side
      // two pins per side pair; managers only on larger parts
      if (s < 16)
      begin : g_left
        assign pin_a = left_half_clock_pin_i[s-8]; // [R11] [R14]
      end
      else
      begin : g_right
        assign pin_a = right_half_clock_pin_i[s-16]; // [R11] [R14]
      end
      assign pin_b = pin_a;
      assign mgr_src = SIDE_MGR_EN ? manager_out_i[s%8] : double_line_i[s]; // [R11]
    end
    assign src = src_sel_q[2*s +: 2];
    assign line_src[s] = (src == cmsg_pkg::SRC_PIN_A) ? pin_a :
                         (src == cmsg_pkg::SRC_PIN_B) ? pin_b :
                         (src == cmsg_pkg::SRC_MGR) ? mgr_src : double_line_i[s];

    // input zero of one member is input one of its partner
    cmsg_glitchless_clock_mux #(
      .KIND(cmsg_pkg::cmsg_kind_t'(MUX_KIND[2*s +: 2]))
    ) u_mux (
      .rst_i(rst_i),
      .mux_input_zero_i(line_src[s]),
      .mux_input_one_i(line_src[s^1]), // [R10]
      .sel_i(mux_sel_q[s]), // [R4]
      .clk_o(mux_clk[s])
    );
  end

  // global lines reach every quadrant, side lines only their half
  assign global_clk_o = mux_clk[7:0]; // [R9]
  assign left_half_clk_o = mux_clk[15:8]; // [R9]
  assign right_half_clk_o = mux_clk[23:16]; // [R9]

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence stall_entry;
    state_q == cmsg_pkg::SEQ_RUN && phase_q == stall_phase && !lock_ok && step_q && !restart_q;
  endsequence

  sequence stall_release;
    state_q == cmsg_pkg::SEQ_STALL && lock_ok && step_q && !restart_q;
  endsequence

  chk_stall_entry: assert property (@(posedge core_clk_i) disable iff (rst_i) // [R3]
    stall_entry |=> state_q == cmsg_pkg::SEQ_STALL && $stable(phase_q))
    else $error("sequencer did not stall at chosen cycle");
  chk_stall_release: assert property (@(posedge core_clk_i) disable iff (rst_i) // [R2]
    stall_release |=> state_q == cmsg_pkg::SEQ_RUN && phase_q == 3'($past(phase_q) + 3'h1))
    else $error("stall not released when locks present");
  chk_no_user_stalled: assert property (@(posedge core_clk_i) disable iff (rst_i) // [R1]
    state_q == cmsg_pkg::SEQ_STALL |=> !user_q)
    else $error("user mode while start-up stalled");
  chk_mask_ignored: assert property (@(posedge core_clk_i) disable iff (rst_i) // [R20]
    wait_mask_q == 8'h00 |-> lock_ok)
    else $error("non-waiting manager blocked start-up");
  chk_reset_unlocks: assert property (@(posedge core_clk_i) disable iff (rst_i) // [R18]
    |(mgr_rst_q & wait_mask_q) |-> !lock_ok)
    else $error("manager in reset counted as lock_indicator");
  chk_lock_follows: assert property (@(posedge core_clk_i) disable iff (rst_i) // [R17]
    (lock_indicator_i[0] && !mgr_rst_q[0]) [*3] |-> lock_eff[0])
    else $error("lock indicator not seen after sync");
  chk_write_answer: assert property (@(posedge core_clk_i) disable iff (rst_i)
    aw_full_q && w_full_q && !bvalid_q |=> bvalid_q [*1] ##0 $stable(wr_addr_q))
    else $error("write response missing");
  chk_read_answer: assert property (@(posedge core_clk_i) disable iff (rst_i)
    ar_take |=> rvalid_q ##1 (rvalid_q || $past(s_axi_rready)))
    else $error("read response dropped early");

endmodule

// ===== cmsg_far_side.sv
// far-side model: clock pins, clock managers and their lock indicators
`timescale 1ns/1ps
module cmsg_far_side (
  input wire logic [7:0] manager_reset_i,
  input wire logic [7:0] lock_ok_i,
  output logic [15:0] global_clock_pin_o,
  output logic [7:0] left_half_clock_pin_o,
  output logic [7:0] right_half_clock_pin_o,
  output logic [23:0] double_line_o,
  output logic [7:0] manager_out_o,
  output logic [7:0] lock_indicator_o
);
  logic [63:0] src;
  // free-running sources, each its own half period so none are related
  for (genvar i = 0; i < 64; i++)
  begin : g_src
    initial
    begin
      src[i] = 1'b0;
      forever #(7 + i) src[i] = ~src[i];
    end
  end
  // source slices onto the pin groups
  assign global_clock_pin_o = src[15:0];
  assign left_half_clock_pin_o = src[23:16];
  assign right_half_clock_pin_o = src[31:24];
  assign double_line_o = src[55:32];
  assign manager_out_o = src[63:56];
  // lock only while phases match and the manager is out of reset
  assign lock_indicator_o = lock_ok_i & ~manager_reset_i;
endmodule

// ===== tb.sv
// self-checking bench for the clock mux and start-up lock gate
`timescale 1ns/1ps
module tb;
  // ----
  // signals
  // ----
  logic clk, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic rst = 1'b1;
  logic user, stall;
  logic [7:0] awaddr, araddr, mgr_rst, lock_ok, lock, lpin, rpin, mout, global_clock_pin, lclk, rclk;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r;
  logic [15:0] gpin;
  logic [23:0] dline, oclk;
  logic [7:0] mic;
  int error_cnt, samples_checked, cycles, g1_cnt, g2_cnt;
  realtime last_t;
  // clock
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  cmsg_clock_mux_startup_lock_gate #(.MUX_KIND(48'h18), .SIDE_MGR_EN(1'b1), .STEP_DIV(2)) i_dut (
    .core_clk_i(clk), .rst_i(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .global_clock_pin_i(gpin), .left_half_clock_pin_i(lpin), .right_half_clock_pin_i(rpin),
    .double_line_i(dline), .manager_out_i(mout), .lock_indicator_i(lock),
    .manager_input_clock_o(mic), .manager_reset_o(mgr_rst), .global_clk_o(global_clock_pin),
    .left_half_clk_o(lclk), .right_half_clk_o(rclk), .user_mode_o(user),
    .startup_stalled_o(stall));
  cmsg_far_side i_far (.manager_reset_i(mgr_rst), .lock_ok_i(lock_ok),
    .global_clock_pin_o(gpin), .left_half_clock_pin_o(lpin), .right_half_clock_pin_o(rpin),
    .double_line_o(dline), .manager_out_o(mout), .lock_indicator_o(lock));
  assign oclk = {rclk, lclk, global_clock_pin};
  // ----
  // helpers
  // ----
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task print_verdict;
    $display("errors=%0d checks=%0d", error_cnt, samples_checked);
    if (error_cnt == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // one write; bready stays up until the response is seen
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    r = bresp;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (arready)
        arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    d = rdata;
    r = rresp;
  endtask
  // bounded wait for user mode, then judge it
  task automatic wait_user();
    int n;
    n = 0;
    while (user !== 1'b1 && n < 200)
    begin
      @(posedge clk);
      n++;
    end
    check({31'h0, user}, 32'h1);
  endtask
  // half period of one mux output once the switch has settled
  task automatic meas(input int idx, input int exp);
    realtime t;
    repeat (10) @(posedge clk);
    wait (oclk[idx] === 1'b0);
    wait (oclk[idx] === 1'b1);
    t = $realtime;
    wait (oclk[idx] === 1'b0);
    check(32'(int'($realtime - t)), 32'(exp));
  endtask
  // ----
  // scenarios
  // ----
  task automatic t_unmapped();
    rd(8'h40);
    check({d[31:2], r}, {30'h0, cmsg_pkg::RESP_DECERR});
    wr(8'h40, 32'hFFFF_FFFF);
    check({30'h0, r}, {30'h0, cmsg_pkg::RESP_DECERR});
  endtask
  // waiting manager 0 unlocked, manager 2 unlocked but not waiting
  task automatic t_stall();
    for (int c = 0; c < 7; c++)
    begin
      lock_ok <= 8'hFA;
      wr(cmsg_pkg::ADDR_WAIT_MASK, 32'h3);
      wr(cmsg_pkg::ADDR_STARTUP, 32'h100 | c);
      repeat (60) @(posedge clk);
      check({31'h0, stall}, 32'h1);
      check({31'h0, user}, 32'h0);
      rd(cmsg_pkg::ADDR_STATUS);
      check({29'h0, d[2:0]}, (c > 5) ? 32'(cmsg_pkg::LOCK_SEL_MAX) : 32'(c));
      lock_ok <= 8'hFB;
      wait_user();
    end
  endtask
  task automatic t_mgr_reset();
    wr(cmsg_pkg::ADDR_MGR_RESET, 32'h1);
    check({24'h0, mgr_rst}, 32'h1);
    repeat (4) @(posedge clk);
    rd(cmsg_pkg::ADDR_STATUS);
    check({24'h0, d[15:8]}, 32'hFA);
    wr(cmsg_pkg::ADDR_MGR_RESET, 32'h0);
  endtask
  // mux 1 is gated, mux 2 is a plain buffer
  task automatic t_mux();
    wr(cmsg_pkg::ADDR_MUX_SEL, 32'h4);
    meas(0, 7);
    g1_cnt = 0;
    g2_cnt = 0;
    repeat (10) @(posedge clk);
    check(32'(g1_cnt), 32'h0);
    check({31'h0, g2_cnt > 0}, 32'h1);
    wr(cmsg_pkg::ADDR_MUX_SEL, 32'h3);
    meas(0, 8);
    g1_cnt = 0;
    repeat (10) @(posedge clk);
    check({31'h0, g1_cnt > 0}, 32'h1);
    wr(cmsg_pkg::ADDR_SRC_LO, 32'h1);
    wr(cmsg_pkg::ADDR_MUX_SEL, 32'h0);
    meas(0, 9);
  endtask
  // side lines from pins, manager and double line; direct manager paths
  task automatic t_side();
    meas(8, 23);
    meas(16, 31);
    wr(cmsg_pkg::ADDR_MUX_SEL, 32'h100);
    meas(8, 24);
    wr(cmsg_pkg::ADDR_MUX_SEL, 32'h0);
    wr(cmsg_pkg::ADDR_SRC_LO, 32'h2_0001);
    meas(8, 63);
    wr(cmsg_pkg::ADDR_SRC_LO, 32'h3_0001);
    meas(8, 47);
    // sample half a nanosecond after the edge, where no pin toggles
    repeat (4)
    begin
      @(posedge clk);
      #0.5;
      d = {24'h0, lpin[4], lpin[0], rpin[4], rpin[0], gpin[12], gpin[8], gpin[4], gpin[0]};
      check({24'h0, mic}, d);
    end
  endtask
  // ----
  // monitors and main sequence
  // ----
  // no output phase of mux 0 may be shorter than the shortest input phase
  always @(global_clock_pin[0])
  begin
    check(32'(rst || ($realtime - last_t >= 7.0)), 32'h1);
    last_t = $realtime;
  end
  always @(posedge global_clock_pin[1]) g1_cnt++;
  always @(posedge global_clock_pin[2]) g2_cnt++;
  // cut a hang short
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      error_cnt++;
      print_verdict();
    end
  end
  initial
  begin
    {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    wstrb = 4'hF;
    lock_ok = 8'hFF;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    wait_user();
    t_unmapped();
    t_stall();
    t_mgr_reset();
    t_mux();
    t_side();
    print_verdict();
  end
endmodule
